//--- src/mca_pkg.sv
// Package: register map, field layout and types of the monitor config block
package mca_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] MCA_IDX_CHAN_SELECT = 8'h55;
   localparam logic [7:0] MCA_IDX_CFG_TWO     = 8'h73;
   localparam logic [7:0] MCA_IDX_MASK_ONE    = 8'h74;
   localparam logic [7:0] MCA_IDX_MASK_TWO    = 8'h75;
   localparam logic [7:0] MCA_IDX_CFG_THREE   = 8'h78;
   localparam logic [7:0] MCA_IDX_CFG_FOUR    = 8'h7D;
   localparam logic [7:0] MCA_IDX_CFG_ONE     = 8'h40;
   localparam logic [7:0] MCA_IDX_STATUS_ONE  = 8'h41;
   localparam logic [7:0] MCA_IDX_STATUS_TWO  = 8'h42;

   // Reset values
   localparam logic [7:0] MCA_RST_BYTE        = 8'h00;

   // Field positions
   localparam int MCA_CFG1_LOCK_BIT     = 1;
   localparam int MCA_CFG3_ALERT_SEL    = 0;
   localparam int MCA_CFG4_ATTENUATOR_BYPASS_LO      = 4;
   localparam int MCA_CHSEL_LO          = 5;
   localparam int MCA_MASK1_GATE_BIT    = 7;
   localparam int MCA_NUM_TACH          = 3;
   localparam int MCA_NUM_ATTENUATOR_BYPASS          = 4;
   localparam int MCA_NUM_CH_ONE        = 7;
   localparam int MCA_NUM_CH_TWO        = 8;

   // Single-channel selector codes
   localparam logic [2:0] MCA_CH_LOW_SUPPLY  = 3'h0;
   localparam logic [2:0] MCA_CH_CORE        = 3'h1;
   localparam logic [2:0] MCA_CH_MAIN_SUPPLY = 3'h2;
   localparam logic [2:0] MCA_CH_FIVE_VOLT   = 3'h3;
   localparam logic [2:0] MCA_CH_TWELVE_VOLT = 3'h4;
   localparam logic [2:0] MCA_CH_REMOTE_ONE  = 3'h5;
   localparam logic [2:0] MCA_CH_LOCAL       = 3'h6;
   localparam logic [2:0] MCA_CH_REMOTE_TWO  = 3'h7;

   // Layout of the fan and conversion configuration register
   typedef struct packed {
      logic       reserved;
      logic       single_channel_convert;
      logic       attenuator_bypass;
      logic       averaging_disable;
      logic [2:0] four_wire_present;
      logic       fan_presence_detect_enable;
   } mca_cfg_two_t;

   // Settings handed to the converter
   typedef struct packed {
      logic       averaging_disable;
      logic [3:0] attenuator_bypass_bypass;
      logic       single_channel_convert;
      logic [2:0] channel;
   } mca_single_channel_convert_ctl_t;

   // Register index match on an Avalon byte address
   function automatic logic mca_hit(input logic [9:0] addr,
                                    input logic [7:0] idx);
      mca_hit = (addr[9:2] == idx);
   endfunction

endpackage

//--- src/mca_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module mca_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule
`default_nettype wire

//--- src/mca_alert.sv
// Alert combiner: unmasked status of both status registers to one level
`timescale 1ns/1ps
`default_nettype none
module mca_alert
   import mca_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   input  wire logic [7:0] status_one_i,
   input  wire logic [7:0] status_two_i,
   input  wire logic [7:0] mask_one_i,
   input  wire logic [7:0] mask_two_i,
   output logic            alert_o
);
   logic       alert_q;
   logic       one_hit;
   logic       two_unmasked;
   logic       two_any;
   logic       gate;

   // Channel masks block the alert only, never the status bits
   assign one_hit = |(status_one_i[MCA_NUM_CH_ONE-1:0]
                      & ~mask_one_i[MCA_NUM_CH_ONE-1:0]);
   assign two_unmasked = |(status_two_i & ~mask_two_i);
   assign two_any      = |status_two_i;
   assign gate         = mask_one_i[MCA_MASK1_GATE_BIT];

   // Gate low lets any second-register alert through despite its masks
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= one_hit | (gate ? two_unmasked : two_any);
      end
   end

   assign alert_o = alert_q;
endmodule
`default_nettype wire

//--- src/mca_top.sv
// Monitor configuration, alert mask and status registers on Avalon-MM
//
// Notes on behaviour
// - Presence enable set makes bits 3:1 show four-wire fan presence.
// - Bits 1..3 are read-only presence flags for tach one..three.
// - Averaging disable bit stops measurement averaging for faster results.
// - Global bypass removes attenuators from four scaled measurement inputs.
// - Per-channel attenuator removal via config four bits 7:4.
// - Single-channel bit makes the converter stay on one input.
// - Selector bits 7:5 of 0x55 pick the single converted input.
// - Lock bit set makes config two ignore all further writes.
// - Mask bit 0 blocks alert from low supply or thermal timer.
// - Mask bits 1..3 block core, main supply and five volt alerts.
// - Mask bits 4..6 block remote one, local, remote two alerts.
// - Gate bit zero lets masked second-register alerts still assert.
// - Alert mask one resets to all zeros.
// - Shared pin carries alert only when alert select is one.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module mca_top
   import mca_pkg::*;
(
   input  wire logic                mclk_i,
   input  wire logic                rst_b_i,
   // Avalon-MM slave
   input  wire logic [9:0]          avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [31:0]         avs_writedata_i,
   input  wire logic [3:0]          avs_byteenable_i,
   output logic      [31:0]         avs_readdata_o,
   output logic                     avs_waitrequest_o,
   // Fan presence sense pins, one per tach input
   // These are asynchronous and pass the synchroniser first
   input  wire logic [2:0]          four_wire_sense_i,
   // Out-of-limit events from the measurement logic, one-cycle pulses
   // Bit order of the first event word follows the mask one bit order
   input  wire logic [6:0]          ool_one_i,
   input  wire logic [7:0]          ool_two_i,
   // Converter handshake
   input  wire logic                single_channel_convert_done_i,
   output mca_single_channel_convert_ctl_t            single_channel_convert_ctl_o,
   // Second fan drive and the shared pin it competes for
   input  wire logic                fan_two_drive_i,
   output logic                     shared_pin_o,
   // Level interrupt, high while an unmasked status bit is set
   output logic                     irq_o
);

   // Register state
   mca_cfg_two_t  cfg_two_q;
   logic [7:0]    mask_one_q;
   logic [7:0]    mask_two_q;
   logic [7:0]    chan_sel_q;
   logic [7:0]    cfg_three_q;
   logic [7:0]    cfg_four_q;
   logic          lock_q;
   logic [7:0]    status_one_q;
   logic [7:0]    status_two_q;
   logic [7:0]    status_one_d;
   logic [7:0]    status_two_d;

   // Bus state
   logic          waitreq_q;
   logic [31:0]   rdata_q;
   logic [31:0]   rdata_d;

   // Outputs held in flops
   mca_single_channel_convert_ctl_t single_channel_convert_ctl_q;
   logic [2:0]    seq_chan_q;
   logic          pin_q;
   logic          alert;

   // Synchronised presence sense; the flags lag the pins by two cycles,
   // so a read right after a fan change may still show the old state
   logic [2:0]    sense_sync;

   mca_sync #(
      .W (MCA_NUM_TACH)
   ) u_sense_sync (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .async_i (four_wire_sense_i),
      .sync_o  (sense_sync)
   );

   // Address decode, shared by read and write paths
   // Bits 1:0 of the byte address take no part in the decode
   wire hit_cfg_two   = mca_hit(avs_address_i, MCA_IDX_CFG_TWO);
   wire hit_mask_one  = mca_hit(avs_address_i, MCA_IDX_MASK_ONE);
   wire hit_mask_two  = mca_hit(avs_address_i, MCA_IDX_MASK_TWO);
   wire hit_chan_sel  = mca_hit(avs_address_i, MCA_IDX_CHAN_SELECT);
   wire hit_cfg_three = mca_hit(avs_address_i, MCA_IDX_CFG_THREE);
   wire hit_cfg_four  = mca_hit(avs_address_i, MCA_IDX_CFG_FOUR);
   wire hit_cfg_one   = mca_hit(avs_address_i, MCA_IDX_CFG_ONE);
   wire hit_stat_one  = mca_hit(avs_address_i, MCA_IDX_STATUS_ONE);
   wire hit_stat_two  = mca_hit(avs_address_i, MCA_IDX_STATUS_TWO);

   // A write lands only at the edge where waitrequest is seen low
   // Writes with the low byte lane disabled are dropped, since every
   // register sits in that lane alone
   wire        wr_fire = avs_write_i & ~waitreq_q & avs_byteenable_i[0];
   wire [7:0]  wbyte   = avs_writedata_i[7:0];

   // Config two writes are dropped once locked; detect bits never written
   wire wr_cfg_two = wr_fire & hit_cfg_two & ~lock_q;

   // Remaining registers take any write that reaches them
   wire wr_mask_one  = wr_fire & hit_mask_one;
   wire wr_mask_two  = wr_fire & hit_mask_two;
   wire wr_chan_sel  = wr_fire & hit_chan_sel;
   wire wr_cfg_three = wr_fire & hit_cfg_three;
   wire wr_cfg_four  = wr_fire & hit_cfg_four;
   wire wr_cfg_one   = wr_fire & hit_cfg_one;
   wire wr_stat_one  = wr_fire & hit_stat_one;
   wire wr_stat_two  = wr_fire & hit_stat_two;

   // Presence flags follow the pins only while detection is enabled
   // Reading zero when disabled avoids reporting a stale pin level
   wire [2:0] presence_view = cfg_two_q.fan_presence_detect_enable
                              ? sense_sync : 3'h0;

   // Read view of config two with live presence flags
   wire [7:0] cfg_two_view = {cfg_two_q.reserved,
                              cfg_two_q.single_channel_convert,
                              cfg_two_q.attenuator_bypass,
                              cfg_two_q.averaging_disable,
                              presence_view,
                              cfg_two_q.fan_presence_detect_enable};

   // Config one reads back only the lock bit
   wire [7:0] cfg_one_view = {6'h00, lock_q, 1'b0};

   // Read data mux; unmapped addresses read as zero
   // The upper byte lanes always read zero
   wire [7:0] rd_byte =
      hit_cfg_two   ? cfg_two_view :
      hit_mask_one  ? mask_one_q   :
      hit_mask_two  ? mask_two_q   :
      hit_chan_sel  ? chan_sel_q   :
      hit_cfg_three ? cfg_three_q  :
      hit_cfg_four  ? cfg_four_q   :
      hit_cfg_one   ? cfg_one_view :
      hit_stat_one  ? status_one_q :
      hit_stat_two  ? status_two_q : 8'h00;

   assign rdata_d = {24'h000000, rd_byte};

   // First cycle of an access: request seen while still waiting
   wire req_first = (avs_read_i | avs_write_i) & waitreq_q;

   // One wait cycle per access keeps decode and read mux off one path;
   // the price is two cycles per access even when requests follow closely
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         waitreq_q <= 1'b1;
      end else begin
         waitreq_q <= ~req_first;
      end
   end

   // Read data loaded in the wait cycle and held until the next access
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= 32'h00000000;
      end else if (req_first) begin
         rdata_q <= rdata_d;
      end
   end

   // Config two: reserved bit stored so software read-modify-write keeps it
   // Presence flags are not stored; the read view builds them from the
   // synchronised pins
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_two_q <= mca_cfg_two_t'(MCA_RST_BYTE);
      end else if (wr_cfg_two) begin
         cfg_two_q.reserved                   <= wbyte[7];
         cfg_two_q.single_channel_convert     <= wbyte[6];
         cfg_two_q.attenuator_bypass          <= wbyte[5];
         cfg_two_q.averaging_disable          <= wbyte[4];
         cfg_two_q.four_wire_present          <= 3'h0;
         cfg_two_q.fan_presence_detect_enable <= wbyte[0];
      end
   end

   // Alert mask one, clear at power-on so every channel can alert
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask_one_q <= MCA_RST_BYTE;
      end else if (wr_mask_one) begin
         mask_one_q <= wbyte;
      end
   end

   // Alert mask two; consulted only while the gate bit of mask one is set
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask_two_q <= MCA_RST_BYTE;
      end else if (wr_mask_two) begin
         mask_two_q <= wbyte;
      end
   end

   // Channel selector; only bits 7:5 pick the input, the rest are kept
   // so that software reads back what it wrote
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chan_sel_q <= MCA_RST_BYTE;
      end else if (wr_chan_sel) begin
         chan_sel_q <= wbyte;
      end
   end

   // Config three; bit 0 hands the shared pin to the alert
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_three_q <= MCA_RST_BYTE;
      end else if (wr_cfg_three) begin
         cfg_three_q <= wbyte;
      end
   end

   // Config four; bits 7:4 remove single attenuators
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_four_q <= MCA_RST_BYTE;
      end else if (wr_cfg_four) begin
         cfg_four_q <= wbyte;
      end
   end

   // Lock is set-only; only a reset releases it
   // Limitation: once set, config two stays frozen until the next reset,
   // so settings must be final before software locks them
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_q <= 1'b0;
      end else if (wr_cfg_one & wbyte[MCA_CFG1_LOCK_BIT]) begin
         lock_q <= 1'b1;
      end
   end

   // Status flags: write one to clear, a new event in the same cycle wins
   // A winning set keeps an event from being lost to a late clear
   wire [7:0] clr_one = wr_stat_one ? wbyte : 8'h00;
   wire [7:0] clr_two = wr_stat_two ? wbyte : 8'h00;

   assign status_one_d = ((status_one_q & ~clr_one) | {1'b0, ool_one_i})
                         & 8'h7F;
   assign status_two_d = (status_two_q & ~clr_two) | ool_two_i;

   // Status one; bit 7 has no channel and always reads zero
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_one_q <= MCA_RST_BYTE;
      end else begin
         status_one_q <= status_one_d;
      end
   end

   // Status two; every bit is a sticky event flag
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_two_q <= MCA_RST_BYTE;
      end else begin
         status_two_q <= status_two_d;
      end
   end

   // Alert level from unmasked status
   // The combiner registers its output, so irq lags status by one cycle
   mca_alert u_alert (
      .mclk_i       (mclk_i),
      .rst_b_i      (rst_b_i),
      .status_one_i (status_one_q),
      .status_two_i (status_two_q),
      .mask_one_i   (mask_one_q),
      .mask_two_i   (mask_two_q),
      .alert_o      (alert)
   );

   // Converter channel: fixed in single mode, else steps on each result
   // The free-running step wraps from the last code back to the first,
   // so all eight inputs are visited in turn
   wire [2:0] sel_code = chan_sel_q[MCA_CHSEL_LO+2:MCA_CHSEL_LO];
   wire       single   = cfg_two_q.single_channel_convert;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seq_chan_q <= MCA_CH_LOW_SUPPLY;
      end else if (single) begin
         seq_chan_q <= sel_code;
      end else if (single_channel_convert_done_i) begin
         seq_chan_q <= seq_chan_q + 3'h1;
      end
   end

   // Attenuator removal per scaled input: global bit or the input's own
   logic [MCA_NUM_ATTENUATOR_BYPASS-1:0] attenuator_bypass_sel;

   for (genvar a = 0; a < MCA_NUM_ATTENUATOR_BYPASS; a++) begin : g_attenuator_bypass
      assign attenuator_bypass_sel[a] = cfg_two_q.attenuator_bypass
                           | cfg_four_q[MCA_CFG4_ATTENUATOR_BYPASS_LO+a];
   end

   // Converter settings registered so the outputs come from flops
   // Cost: one extra cycle between a register write and the converter
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         single_channel_convert_ctl_q <= '0;
      end else begin
         single_channel_convert_ctl_q.averaging_disable      <= cfg_two_q.averaging_disable;
         single_channel_convert_ctl_q.attenuator_bypass_bypass            <= attenuator_bypass_sel;
         single_channel_convert_ctl_q.single_channel_convert <= single;
         single_channel_convert_ctl_q.channel                <= seq_chan_q;
      end
   end

   // Shared pin: alert or second fan drive, one cycle behind either source
   // The pin idles low in reset, leaving both fan drive and alert off
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= cfg_three_q[MCA_CFG3_ALERT_SEL]
                  ? alert : fan_two_drive_i;
      end
   end

   // Top outputs, each straight from a flop
   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = waitreq_q;
   assign single_channel_convert_ctl_o        = single_channel_convert_ctl_q;
   assign shared_pin_o      = pin_q;
   assign irq_o             = alert;

endmodule
`default_nettype wire

//--- sim/mca_top_chk.sv
// Checker: port-level assertions for the monitor config block
`timescale 1ns/1ps
`default_nettype none
module mca_top_chk
   import mca_pkg::*;
(
   input  wire logic          mclk_i,
   input  wire logic          rst_b_i,
   input  wire logic [9:0]    avs_address_i,
   input  wire logic          avs_read_i,
   input  wire logic          avs_write_i,
   input  wire logic [31:0]   avs_writedata_i,
   input  wire logic [3:0]    avs_byteenable_i,
   input  wire logic [31:0]   avs_readdata_o,
   input  wire logic          avs_waitrequest_o,
   input  wire logic [6:0]    ool_one_i,
   input  wire logic [7:0]    ool_two_i,
   input  wire logic          fan_two_drive_i,
   input  wire mca_single_channel_convert_ctl_t single_channel_convert_ctl_o,
   input  wire logic          shared_pin_o,
   input  wire logic          irq_o
);
   logic       wr;
   logic       rd73;
   logic [7:0] cfg_q;
   logic [7:0] m1_q;
   logic       sel_q;
   logic       lock_q;

   // Accepted bus cycles; only the low byte lane carries a register
   assign wr   = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign rd73 = avs_read_i && !avs_waitrequest_o
                 && mca_hit(avs_address_i, MCA_IDX_CFG_TWO);

   // Shadow of written settings; the lock can only be set until reset
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_q  <= 8'h00;
         m1_q   <= 8'h00;
         sel_q  <= 1'b0;
         lock_q <= 1'b0;
      end else if (wr) begin
         if (mca_hit(avs_address_i, MCA_IDX_CFG_TWO) && !lock_q)
            cfg_q <= avs_writedata_i[7:0] & 8'hF1;
         if (mca_hit(avs_address_i, MCA_IDX_MASK_ONE))
            m1_q <= avs_writedata_i[7:0];
         if (mca_hit(avs_address_i, MCA_IDX_CFG_THREE))
            sel_q <= avs_writedata_i[0];
         if (mca_hit(avs_address_i, MCA_IDX_CFG_ONE) && avs_writedata_i[1])
            lock_q <= 1'b1;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   a_cfg_locked: assert property (
      rd73 |-> avs_readdata_o[7:4] == cfg_q[7:4]
               && avs_readdata_o[0] == cfg_q[0])
      else $error("config two read differs from accepted writes");
   a_flags_off: assert property (
      rd73 && !cfg_q[0] |-> avs_readdata_o[3:1] == 3'h0)
      else $error("presence flags shown while detection is off");
   a_event_alert: assert property (
      (|(ool_one_i & ~m1_q[6:0])) && !wr |=> ##1 irq_o)
      else $error("unmasked event did not raise the alert");
   a_gate_open: assert property (
      (|ool_two_i) && !m1_q[7] && !wr |=> ##1 irq_o)
      else $error("second status event blocked with gate clear");
   a_pin_fan: assert property (
      $past(rst_b_i) && !$past(sel_q)
         |-> shared_pin_o == $past(fan_two_drive_i))
      else $error("shared pin does not carry fan drive");
   a_pin_alert: assert property (
      $past(rst_b_i) && $past(sel_q) |-> shared_pin_o == $past(irq_o))
      else $error("shared pin does not carry the alert");
   a_avg_follow: assert property (
      single_channel_convert_ctl_o.averaging_disable == $past(cfg_q[4]))
      else $error("averaging control does not follow config two");
   a_single_follow: assert property (
      single_channel_convert_ctl_o.single_channel_convert == $past(cfg_q[6]))
      else $error("single channel control does not follow config two");
   a_bypass_all: assert property (
      $past(cfg_q[5]) |-> single_channel_convert_ctl_o.attenuator_bypass_bypass == 4'hF)
      else $error("global bypass left an attenuator in place");
endmodule

bind mca_top mca_top_chk u_chk (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .ool_one_i(ool_one_i), .ool_two_i(ool_two_i),
   .fan_two_drive_i(fan_two_drive_i), .single_channel_convert_ctl_o(single_channel_convert_ctl_o),
   .shared_pin_o(shared_pin_o), .irq_o(irq_o)
);
`default_nettype wire

//--- sim/mca_top_tb.sv
// Testbench: random and corner-case register, alert and pin checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
   num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
   $time, g, e); end end
module mca_top_tb
   import mca_pkg::*;
;
   logic          mclk_i = 1'b0;
   logic          rst_b_i = 1'b0;
   logic [9:0]    avs_address_i = 10'h000;
   logic          avs_read_i = 1'b0;
   logic          avs_write_i = 1'b0;
   logic [31:0]   avs_writedata_i = 32'h0;
   logic [3:0]    avs_byteenable_i = 4'hF;
   logic [31:0]   avs_readdata_o;
   logic          avs_waitrequest_o;
   logic [2:0]    four_wire_sense_i = 3'h0;
   logic [6:0]    ool_one_i = 7'h00;
   logic [7:0]    ool_two_i = 8'h00;
   logic          single_channel_convert_done_i = 1'b0;
   mca_single_channel_convert_ctl_t single_channel_convert_ctl_o;
   logic          fan_two_drive_i = 1'b0;
   logic          shared_pin_o;
   logic          irq_o;
   logic [31:0]   lfsr = 32'h9EA4;
   logic [7:0]    rd;
   logic [7:0]    m;
   logic [7:0]    idxs [4] = '{MCA_IDX_CFG_TWO, MCA_IDX_MASK_ONE,
                               MCA_IDX_MASK_TWO, 8'h10};
   int            num_errors = 0;
   int            tests_run = 0;
   int            cycles = 0;

   mca_top DUT (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .four_wire_sense_i(four_wire_sense_i), .ool_one_i(ool_one_i),
      .ool_two_i(ool_two_i), .single_channel_convert_done_i(single_channel_convert_done_i),
      .single_channel_convert_ctl_o(single_channel_convert_ctl_o), .fan_two_drive_i(fan_two_drive_i),
      .shared_pin_o(shared_pin_o), .irq_o(irq_o)
   );

   // Free-running 100 MHz clock
   always #5 mclk_i = ~mclk_i;

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end

   // Galois step; fixed start keeps every run the same
   function automatic logic [31:0] nxt(input logic [31:0] s);
      nxt = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction

   // Config two readback: flags show the pins only while enabled
   function automatic logic [7:0] exp_cfg(input logic [7:0] w,
                                          input logic [2:0] s);
      exp_cfg = (w & 8'hF1) | (w[0] ? {4'h0, s, 1'b0} : 8'h00);
   endfunction

   // One bus cycle; holds the request until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
      avs_address_i   <= {idx, 2'b00};
      avs_read_i      <= !w;
      avs_write_i     <= w;
      avs_writedata_i <= {24'h0, d};
      @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
      rd = avs_readdata_o[7:0];
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic conclude();
      $display("Mismatches %0d, comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(posedge mclk_i);
      // Reset values, an unmapped index among them
      foreach (idxs[i]) begin
         bus(1'b0, idxs[i], 8'h00);
         `CHK(rd, MCA_RST_BYTE)
      end
      // Free-running sequence steps once per finished conversion, wraps
      for (int n = 1; n < 10; n++) begin
         single_channel_convert_done_i <= 1'b1;
         @(posedge mclk_i);
         single_channel_convert_done_i <= 1'b0;
         repeat (3) @(posedge mclk_i);
         `CHK(single_channel_convert_ctl_o.channel, n[2:0])
      end
      // Flag bits written as ones must not stick; reserved bit kept 0
      lfsr = nxt(lfsr);
      four_wire_sense_i <= lfsr[2:0];
      for (int i = 0; i < 2; i++) begin
         m = i ? 8'h7F : 8'h7E;
         bus(1'b1, MCA_IDX_CFG_TWO, m);
         repeat (3) @(posedge mclk_i);
         bus(1'b0, MCA_IDX_CFG_TWO, 8'h00);
         `CHK(rd, exp_cfg(m, four_wire_sense_i))
      end
      // Per-channel bypass and every selector code in single mode
      bus(1'b1, MCA_IDX_CFG_TWO, 8'h41);
      bus(1'b1, MCA_IDX_CFG_FOUR, 8'hA5);
      repeat (2) @(posedge mclk_i);
      `CHK(single_channel_convert_ctl_o.attenuator_bypass_bypass, 4'hA)
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, MCA_IDX_CHAN_SELECT, {c[2:0], 5'h00});
         repeat (3) @(posedge mclk_i);
         `CHK(single_channel_convert_ctl_o.channel, c[2:0])
      end
      // Each channel twice under random masks; status records regardless
      bus(1'b1, MCA_IDX_CFG_THREE, 8'h01);
      for (int k = 0; k < 14; k++) begin
         lfsr = nxt(lfsr);
         m = lfsr[7:0];
         bus(1'b1, MCA_IDX_MASK_ONE, m);
         ool_one_i <= 7'h01 << (k % 7);
         @(posedge mclk_i);
         ool_one_i <= 7'h00;
         repeat (3) @(posedge mclk_i);
         `CHK(irq_o, !m[k % 7])
         bus(1'b0, MCA_IDX_STATUS_ONE, 8'h00);
         `CHK(rd, 8'h01 << (k % 7))
         bus(1'b1, MCA_IDX_STATUS_ONE, 8'h7F);
      end
      // Fully masked second status: gate decides
      bus(1'b1, MCA_IDX_MASK_TWO, 8'hFF);
      for (int g = 0; g < 2; g++) begin
         bus(1'b1, MCA_IDX_MASK_ONE, g ? 8'hFF : 8'h7F);
         lfsr = nxt(lfsr);
         ool_two_i <= lfsr[7:0] | 8'h01;
         @(posedge mclk_i);
         ool_two_i <= 8'h00;
         repeat (3) @(posedge mclk_i);
         `CHK(irq_o, g == 0)
         `CHK(shared_pin_o, g == 0)
         bus(1'b1, MCA_IDX_STATUS_TWO, 8'hFF);
      end
      // Shared pin returns to the fan drive
      bus(1'b1, MCA_IDX_CFG_THREE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         fan_two_drive_i <= (i < 2) ? i[0] : lfsr[0];
         repeat (2) @(posedge mclk_i);
         `CHK(shared_pin_o, fan_two_drive_i)
      end
      // After locking, a config two write is dropped
      bus(1'b1, MCA_IDX_CFG_ONE, 8'h02);
      bus(1'b1, MCA_IDX_CFG_TWO, 8'h30);
      bus(1'b0, MCA_IDX_CFG_TWO, 8'h00);
      `CHK(rd, exp_cfg(8'h41, four_wire_sense_i))
      conclude();
   end
endmodule
`default_nettype wire
